// *** hdl/timer_mode_defs.vh ***
// constants for the three eight-bit timer mode control registers
`ifndef TIMER_MODE_DEFS_VH
`define TIMER_MODE_DEFS_VH
`define TMC_ADDR_W 16
`define TMC0_ADDR 16'hff70
`define TMC1_ADDR 16'hff74
`define TMC2_ADDR 16'hff78
`define TMC_RESET 8'h00
`define TMC_BIT_CE 7
`define TMC_BIT_PWM 6
`define TMC_BIT_CASC 4
`define TMC_BIT_SET 3
`define TMC_BIT_CLR 2
`define TMC_BIT_INV 1
`define TMC_BIT_OE 0
`define TMC_RW_MASK 8'hd3
`define TMC_RW_MASK0 8'hc3
`endif

// *** hdl/timer_channel.v ***
// one eight-bit counter channel with compare, output flip-flop and pwm
`timescale 1ns/1ps
module timer_channel #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // control
  input wire count_enable_bit,
  input wire pwm_mode_select,
  input wire invert_or_polarity_select,
  input wire output_pin_enable,
  input wire output_ff_set_cmd,
  input wire output_ff_reset_cmd,
  // count and compare
  input wire count_tick,
  input wire [WIDTH-1:0] compare_value,
  input wire [7:0] compare_high,
  input wire [7:0] count_high,
  input wire cascade_low,
  input wire high_clear,
  input wire high_match,
  // results
  output reg [WIDTH-1:0] eight_bit_counter,
  output wire match,
  output wire wrap,
  output reg compare_match_irq,
  output reg timer_out,
  output reg timer_out_en
);
  reg output_ff_reg;
  wire at_match;
  wire full_match;
  // a cascaded lower half gives full_match only when the upper half matches too; match is the lower byte alone
  assign at_match = (eight_bit_counter == compare_value) & count_enable_bit & count_tick;
  assign full_match = at_match & (~cascade_low | high_match);
  assign match = at_match;
  assign wrap = count_tick & count_enable_bit & (&eight_bit_counter);

  // counter: cleared when stopped, on match in clear-start mode, or by cascade partner
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      eight_bit_counter <= {WIDTH{1'b0}};
    end else if (!count_enable_bit || high_clear) begin
      eight_bit_counter <= {WIDTH{1'b0}};
    end else if (!pwm_mode_select && full_match) begin
      eight_bit_counter <= {WIDTH{1'b0}};
    end else if (count_tick) begin
      eight_bit_counter <= eight_bit_counter + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // irq pulse on match outside pwm mode
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_match_irq <= 1'b0;
    end else begin
      compare_match_irq <= full_match & ~pwm_mode_select;
    end
  end

  // output flip-flop: commands win over toggle and pwm edges
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      output_ff_reg <= 1'b0;
    end else if (output_ff_reset_cmd) begin
      output_ff_reg <= 1'b0;
    end else if (output_ff_set_cmd) begin
      output_ff_reg <= 1'b1;
    end else if (pwm_mode_select) begin
      if (!count_enable_bit) begin
        output_ff_reg <= 1'b0;
      end else if (wrap) begin
        output_ff_reg <= 1'b1;
      end else if (at_match) begin
        output_ff_reg <= 1'b0;
      end
    end else if (full_match && invert_or_polarity_select) begin
      output_ff_reg <= ~output_ff_reg;
    end
  end

  // pin drive; polarity applies only in pwm mode
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      timer_out <= pwm_mode_select ? (output_ff_reg ^ invert_or_polarity_select) : output_ff_reg;
      timer_out_en <= output_pin_enable;
    end
  end
endmodule // timer_channel

// *** hdl/timer_mode_control.v ***
// three eight-bit timers with their mode control registers
// Behaviour
// - all three control registers reset to 00h: stopped, clear-start, single, output off.
// - control registers take single-bit and whole-byte writes.
// - bit 7 starts counting; at 0 counter clears and holds, prescaler off.
// - bit 6 at 0 is clear-on-match mode, at 1 free-running pwm.
// - bit 4 of timers 1 and 2 selects cascade; fixed 0 on timer 0.
// - bits 3:2 written 01 reset, 10 set output flip-flop; 11 forbidden.
// - set and reset bits are one-shot and read back as 0.
// - bit 1 enables toggle outside pwm, selects low-active output in pwm.
// - bit 0 drives timer output onto pin; at 0 port keeps pin.
// - in pwm mode with count disabled output sits at inactive level.
// - counter clears on reset, on count disable, on match in clear mode.
// - clear-mode match clears counter, keeps counting, raises irq.
// - counter increments on rising edge of its count clock.
// - cascade compares sixteen bits; match raises lower timer irq.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module timer_mode_control #(
  parameter CHANNELS = 3
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // processor access
  input wire [`TMC_ADDR_W-1:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_bit_wr,
  input wire [2:0] cpu_bit_sel,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  output reg [7:0] cpu_rdata,
  output wire cpu_hit,
  // count clocks, one per timer, from pins or prescaler
  input wire [CHANNELS-1:0] count_clk_in,
  input wire [8*CHANNELS-1:0] compare_value,
  // counters and events
  output wire [8*CHANNELS-1:0] eight_bit_counter,
  output wire [CHANNELS-1:0] compare_match_irq,
  output wire [CHANNELS-1:0] timer_out,
  output wire [CHANNELS-1:0] timer_out_en
);
  reg [7:0] ctrl_reg [0:CHANNELS-1];
  reg [7:0] ctrl_next [0:CHANNELS-1];
  reg [CHANNELS-1:0] set_cmd_reg;
  reg [CHANNELS-1:0] clr_cmd_reg;
  reg [CHANNELS-1:0] clk_sync1_reg;
  reg [CHANNELS-1:0] clk_sync2_reg;
  reg [CHANNELS-1:0] clk_prev_reg;
  wire [CHANNELS-1:0] tick;
  wire [CHANNELS-1:0] sel;
  wire [CHANNELS-1:0] ch_match;
  wire [CHANNELS-1:0] ch_wrap;
  wire [CHANNELS-1:0] ch_irq;
  wire [CHANNELS-1:0] casc;
  integer i;
  integer j;

  // count clock pins pass two flops before the edge detector
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync1_reg <= {CHANNELS{1'b0}};
      clk_sync2_reg <= {CHANNELS{1'b0}};
      clk_prev_reg <= {CHANNELS{1'b0}};
    end else begin
      clk_sync1_reg <= count_clk_in;
      clk_sync2_reg <= clk_sync1_reg;
      clk_prev_reg <= clk_sync2_reg;
    end
  end
  assign tick = clk_sync2_reg & ~clk_prev_reg;

  assign sel[0] = (cpu_addr == `TMC0_ADDR);
  assign sel[1] = (cpu_addr == `TMC1_ADDR);
  assign sel[2] = (cpu_addr == `TMC2_ADDR);
  assign cpu_hit = |sel;

  // next register value for byte or single-bit stores
  always @* begin
    for (i = 0; i < CHANNELS; i = i + 1) begin
      ctrl_next[i] = ctrl_reg[i];
      if (sel[i] && cpu_wr) begin
        ctrl_next[i] = cpu_wdata;
      end else if (sel[i] && cpu_bit_wr) begin
        ctrl_next[i][cpu_bit_sel] = cpu_wdata[0];
      end
    end
  end

  // stored bits for all timers in one process so each register has one driver
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        ctrl_reg[j] <= `TMC_RESET;
      end
      set_cmd_reg <= {CHANNELS{1'b0}};
      clr_cmd_reg <= {CHANNELS{1'b0}};
    end else begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        // set/reset command bits are never stored; timer 0 has no cascade bit
        ctrl_reg[j] <= ctrl_next[j] & ((j == 0) ? `TMC_RW_MASK0 : `TMC_RW_MASK);
        // 11 is forbidden; treated as no change
        set_cmd_reg[j] <= ctrl_next[j][`TMC_BIT_SET] & ~ctrl_next[j][`TMC_BIT_CLR] & sel[j] & (cpu_wr | cpu_bit_wr);
        clr_cmd_reg[j] <= ctrl_next[j][`TMC_BIT_CLR] & ~ctrl_next[j][`TMC_BIT_SET] & sel[j] & (cpu_wr | cpu_bit_wr);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : chan
      wire cascade_low;
      wire high_clear;
      wire high_match;
      wire [7:0] cmp_hi;
      wire [7:0] cnt_hi;
      wire ch_tick;

      assign casc[g] = ctrl_reg[g][`TMC_BIT_CASC];
      if (g < CHANNELS - 1) begin : hi_link
        // lower half of a pair: upper timer decides the full match
        assign cascade_low = casc[g+1];
        assign cmp_hi = compare_value[8*(g+1)+7:8*(g+1)];
        assign cnt_hi = eight_bit_counter[8*(g+1)+7:8*(g+1)];
        assign high_match = (cnt_hi == cmp_hi);
      end else begin : hi_none
        assign cascade_low = 1'b0;
        assign cmp_hi = 8'h00;
        assign cnt_hi = 8'h00;
        assign high_match = 1'b0;
      end
      if (g > 0) begin : lo_link
        // upper half counts on lower wrap and clears on the lower irq or while the lower timer is stopped
        assign ch_tick = casc[g] ? ch_wrap[g-1] : tick[g];
        assign high_clear = casc[g] & ((~ctrl_reg[g-1][`TMC_BIT_CE]) |
          (ch_irq[g-1]));
      end else begin : lo_none
        assign ch_tick = tick[g];
        assign high_clear = 1'b0;
      end

      timer_channel #(.WIDTH(8)) u_chan (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .count_enable_bit(ctrl_reg[g][`TMC_BIT_CE]),
        .pwm_mode_select(ctrl_reg[g][`TMC_BIT_PWM]),
        .invert_or_polarity_select(ctrl_reg[g][`TMC_BIT_INV]),
        .output_pin_enable(ctrl_reg[g][`TMC_BIT_OE]),
        .output_ff_set_cmd(set_cmd_reg[g]),
        .output_ff_reset_cmd(clr_cmd_reg[g]),
        .count_tick(ch_tick),
        .compare_value(compare_value[8*g+7:8*g]),
        .compare_high(cmp_hi),
        .count_high(cnt_hi),
        .cascade_low(cascade_low),
        .high_clear(high_clear),
        .high_match(high_match),
        .eight_bit_counter(eight_bit_counter[8*g+7:8*g]),
        .match(ch_match[g]),
        .wrap(ch_wrap[g]),
        .compare_match_irq(ch_irq[g]),
        .timer_out(timer_out[g]),
        .timer_out_en(timer_out_en[g])
      );
      // stopping raises no irq here; software masking is still expected
      assign compare_match_irq[g] = ch_irq[g];
    end
  endgenerate

  // read data registered; command bits always read zero
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= sel[0] ? ctrl_reg[0] : sel[1] ? ctrl_reg[1] : sel[2] ? ctrl_reg[2] : 8'h00;
    end
  end
endmodule // timer_mode_control

// *** verif/timer_mode_monitor.sv ***
// port checker for the three timer mode control registers
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module timer_mode_monitor (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // processor access
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_bit_wr,
  input wire [2:0] cpu_bit_sel,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire cpu_hit,
  // timers
  input wire [2:0] count_clk_in,
  input wire [23:0] compare_value,
  input wire [23:0] eight_bit_counter,
  input wire [2:0] compare_match_irq,
  input wire [2:0] timer_out,
  input wire [2:0] timer_out_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // counter step, irq pulse, pin and stop checks cover timer 0 only; the reset check covers all three timers
  wire [7:0] cnt0 = eight_bit_counter[7:0];
  wire wr0 = cpu_wr && cpu_addr == `TMC0_ADDR;
  chk_hit_decode: assert property (cpu_hit == (cpu_addr == `TMC0_ADDR || cpu_addr == `TMC1_ADDR
    || cpu_addr == `TMC2_ADDR)) else $error("hit decode wrong");
  chk_unmapped_zero: assert property (cpu_rd && !cpu_hit |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_oneshot_reads: assert property (cpu_rd |=> cpu_rdata[5] == 1'b0 && cpu_rdata[3:2] == 2'b00)
    else $error("command bits read back");
  chk_single_only: assert property (cpu_rd && cpu_addr == `TMC0_ADDR |=> !cpu_rdata[4])
    else $error("timer 0 cascade bit set");
  chk_reset_quiet: assert property ($rose(reset_n) |-> eight_bit_counter == 24'h000000
    && timer_out_en == 3'h0 && compare_match_irq == 3'h0) else $error("outputs active after reset");
  chk_count_step: assert property (!$stable(cnt0) |-> cnt0 == $past(cnt0) + 8'h01 || cnt0 == 8'h00)
    else $error("counter jumped");
  chk_irq_pulse: assert property (compare_match_irq[0] |=> !compare_match_irq[0])
    else $error("irq longer than one cycle");
  chk_pin_enable: assert property (wr0 |-> ##2 timer_out_en[0] == $past(cpu_wdata[0], 2))
    else $error("pin enable not following bit 0");
  chk_stop_clears: assert property (wr0 && !cpu_wdata[7] |-> ##2 cnt0 == 8'h00)
    else $error("counter not cleared on stop");
endmodule // timer_mode_monitor
bind timer_mode_control timer_mode_monitor mon (.core_clk, .reset_n, .cpu_addr, .cpu_wr, .cpu_bit_wr,
  .cpu_bit_sel, .cpu_wdata, .cpu_rd, .cpu_rdata, .cpu_hit, .count_clk_in, .compare_value,
  .eight_bit_counter, .compare_match_irq, .timer_out, .timer_out_en);

// *** verif/tb_top.sv ***
// self-checking bench for the timer mode control block
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module tb_top;
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg [15:0] cpu_addr = 16'h0000;
  reg cpu_wr = 1'b0;
  reg cpu_bit_wr = 1'b0;
  reg [2:0] cpu_bit_sel = 3'h0;
  reg [7:0] cpu_wdata = 8'h00;
  reg cpu_rd = 1'b0;
  reg [2:0] count_clk_in = 3'h0;
  reg [23:0] compare_value = 24'h000005;
  wire [7:0] cpu_rdata;
  wire cpu_hit;
  wire [23:0] eight_bit_counter;
  wire [2:0] compare_match_irq, timer_out, timer_out_en;
  integer fails = 0;
  integer compares = 0;
  integer n_irq = 0;
  integer i;
  reg [7:0] rv;
  reg [15:0] a;
  timer_mode_control uut (.core_clk, .reset_n, .cpu_addr, .cpu_wr, .cpu_bit_wr, .cpu_bit_sel,
    .cpu_wdata, .cpu_rd, .cpu_rdata, .cpu_hit, .count_clk_in, .compare_value,
    .eight_bit_counter, .compare_match_irq, .timer_out, .timer_out_en);
  always #20 core_clk = ~core_clk;
  // count timer 0 match pulses
  always @(posedge core_clk) if (compare_match_irq[0]) n_irq <= n_irq + 1;
  task idle(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // byte write, then a gap cycle so strobes never retoggle in one step
  task wr(input [15:0] ad, input [7:0] d);
    cpu_addr = ad;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    idle(1);
    cpu_wr = 1'b0;
    idle(1);
  endtask
  task wb(input [15:0] ad, input [2:0] s, input v);
    cpu_addr = ad;
    cpu_bit_sel = s;
    cpu_wdata = {7'h00, v};
    cpu_bit_wr = 1'b1;
    idle(1);
    cpu_bit_wr = 1'b0;
    idle(1);
  endtask
  task rd(input [15:0] ad);
    cpu_addr = ad;
    cpu_rd = 1'b1;
    idle(1);
    cpu_rd = 1'b0;
    rv = cpu_rdata;
    idle(1);
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pulses wide enough for the two-flop synchroniser; stopped timers ignore them
  task tick(input integer n);
    repeat (n) begin
      count_clk_in = 3'h7;
      idle(4);
      count_clk_in = 3'h0;
      idle(4);
    end
  endtask
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    idle(8);
    reset_n = 1'b1;
    idle(2);
    for (i = 0; i < 3; i = i + 1) begin
      a = `TMC0_ADDR | {12'h000, i[1:0], 2'b00};
      rd(a);
      chk("reset", `TMC_RESET, rv);
      wr(a, 8'hf3);
      rd(a);
      chk("mask", (i == 0) ? `TMC_RW_MASK0 : `TMC_RW_MASK, rv);
      wr(a, 8'h00);
    end
    wb(`TMC1_ADDR, 3'd7, 1'b1);
    rd(`TMC1_ADDR);
    chk("bitwr", 8'h80, rv);
    wb(`TMC1_ADDR, 3'd7, 1'b0);
    wb(`TMC1_ADDR, 3'd3, 1'b1);
    rd(`TMC1_ADDR);
    chk("bitset", 8'h00, rv);
    chk("ff1", 8'h01, {7'h00, timer_out[1]});
    rd(16'hff71);
    chk("unmapped", 8'h00, rv);
    wr(`TMC0_ADDR, 8'h09);
    idle(2);
    chk("set", 8'h03, {6'h00, timer_out_en[0], timer_out[0]});
    rd(`TMC0_ADDR);
    chk("oneshot", 8'h01, rv);
    wr(`TMC0_ADDR, 8'h05);
    idle(2);
    chk("clr", 8'h02, {6'h00, timer_out_en[0], timer_out[0]});
    wr(`TMC0_ADDR, 8'h01);
    idle(2);
    chk("keep", 8'h02, {6'h00, timer_out_en[0], timer_out[0]});
    wr(`TMC0_ADDR, 8'h83);
    tick(2);
    chk("count", 8'h02, eight_bit_counter[7:0]);
    tick(4);
    idle(2);
    chk("irq", 8'h01, n_irq[7:0]);
    chk("toggle", 8'h03, {6'h00, timer_out_en[0], timer_out[0]});
    tick(6);
    chk("irq2", 8'h02, n_irq[7:0]);
    chk("toggle2", 8'h02, {6'h00, timer_out_en[0], timer_out[0]});
    wr(`TMC0_ADDR, 8'h01);
    tick(2);
    chk("stop", 8'h00, eight_bit_counter[7:0]);
    wr(`TMC0_ADDR, 8'h81);
    tick(6);
    chk("irq3", 8'h03, n_irq[7:0]);
    chk("noinv", 8'h02, {6'h00, timer_out_en[0], timer_out[0]});
    wr(`TMC2_ADDR, 8'h41);
    idle(2);
    chk("pwmhi", 8'h02, {6'h00, timer_out_en[2], timer_out[2]});
    wr(`TMC2_ADDR, 8'h43);
    idle(2);
    chk("pwmlo", 8'h03, {6'h00, timer_out_en[2], timer_out[2]});
    // pair 0+1: a lower-byte match alone must neither clear nor interrupt
    compare_value = 24'h000105;
    wr(`TMC1_ADDR, 8'h90);
    tick(261);
    chk("casc_hi", 8'h01, eight_bit_counter[15:8]);
    chk("casc_lo", 8'h05, eight_bit_counter[7:0]);
    chk("casc_nirq", 8'h03, n_irq[7:0]);
    tick(1);
    idle(2);
    chk("casc_irq", 8'h04, n_irq[7:0]);
    chk("casc_clr", 8'h00, eight_bit_counter[15:8]);
    // timer 2 free-running pwm, high active, compare 00
    wr(`TMC2_ADDR, 8'hc1);
    tick(255);
    chk("pwm_cnt", 8'hff, eight_bit_counter[23:16]);
    chk("pwm_idle", 8'h02, {6'h00, timer_out_en[2], timer_out[2]});
    tick(1);
    chk("pwm_on", 8'h03, {6'h00, timer_out_en[2], timer_out[2]});
    tick(1);
    chk("pwm_off", 8'h02, {6'h00, timer_out_en[2], timer_out[2]});
    give_verdict;
  end
endmodule // tb_top
